// ==== design/sdra_ctrl.sv ====
// Purpose: Controller end: one closed-page access per request, reads buffered
// Assumes: Device in fixed burst mode with BURST_LEN elements
// Notes:   Serial access trades bandwidth for trivially met spacing limits
`timescale 1ns/1ps
module sdra_ctrl #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                          i_mclk,      // System clock
  input  wire logic                          i_reset,     // Async reset, high
  sdra_if.ctrl                               bus,         // Memory bus
  input  wire logic                          i_lat3,      // Read latency 3, else 2
  input  wire logic                          i_req_valid, // Request offered
  output logic                               o_req_ready, // Request taken when both high
  input  wire logic                          i_req_write, // Write, else read burst
  input  wire logic [sdra_pkg::BANK_W-1:0]   i_req_bank,  // Bank
  input  wire logic [sdra_pkg::ROW_W-1:0]    i_req_row,   // Row
  input  wire logic [sdra_pkg::COL_W-1:0]    i_req_col,   // Start column
  input  wire logic [sdra_pkg::DATA_W-1:0]   i_req_wdata, // Write word
  output logic                               o_rd_valid,  // Read word available
  input  wire logic                          i_rd_ready,  // Read word consumed
  output logic [sdra_pkg::DATA_W-1:0]        o_rd_data    // Read word
);
  localparam int CNT_W   = 8;
  localparam int FCNT_W  = $clog2(FIFO_DEPTH + 1);
  // Next open may hit any bank, so the longer spacing governs
  localparam int ACT_GAP = (sdra_pkg::RC_CYC > sdra_pkg::RRD_CYC) ?
                           sdra_pkg::RC_CYC : sdra_pkg::RRD_CYC;

  generate
    if (FIFO_DEPTH < sdra_pkg::BURST_LEN || ACT_GAP >= (1 << CNT_W)) begin : g_bad
      $error("sdra_ctrl: FIFO too small or timing count too wide");
    end
  endgenerate

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_RCD   = 5'b00010,
    S_CMD   = 5'b00100,
    S_DRAIN = 5'b01000,
    S_RP    = 5'b10000
  } sdra_state_e;

  sdra_state_e                  state_reg;
  logic [CNT_W-1:0]             cnt_reg;
  logic [CNT_W-1:0]             gap_reg;
  logic                         ready_reg;
  logic                         wr_reg;
  logic [sdra_pkg::COL_W-1:0]   col_reg;
  logic [sdra_pkg::DATA_W-1:0]  wdata_reg;
  sdra_pkg::sdra_cmd_e          cmd_reg;
  logic [sdra_pkg::BANK_W-1:0]  bank_reg;
  logic [sdra_pkg::ADDR_W-1:0]  addr_reg;
  logic [sdra_pkg::DATA_W-1:0]  dq_reg;
  logic                         dq_oe_reg;
  logic                         fifo_in_ready;
  logic [FCNT_W-1:0]            fifo_count;
  logic                         room;
  logic                         take;

  assign room = fifo_in_ready &&
                (fifo_count <= FCNT_W'(FIFO_DEPTH - sdra_pkg::BURST_LEN));
  assign take = i_req_valid && ready_reg;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
      cnt_reg   <= '0;
      ready_reg <= 1'b0;
      wr_reg    <= 1'b0;
      col_reg   <= '0;
      wdata_reg <= '0;
      cmd_reg   <= sdra_pkg::CMD_NOP;
      bank_reg  <= '0;
      addr_reg  <= '0;
      dq_reg    <= '0;
      dq_oe_reg <= 1'b0;
    end else begin
      cmd_reg   <= sdra_pkg::CMD_NOP;
      dq_oe_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          ready_reg <= room && (gap_reg == '0) && !take;
          if (take) begin
            cmd_reg   <= sdra_pkg::CMD_ACT;
            bank_reg  <= i_req_bank;
            addr_reg  <= sdra_pkg::ADDR_W'(i_req_row);
            wr_reg    <= i_req_write;
            col_reg   <= i_req_col;
            wdata_reg <= i_req_wdata;
            cnt_reg   <= CNT_W'(sdra_pkg::RCD_CYC - 1);
            state_reg <= S_RCD;
          end
        end
        S_RCD: begin
          if (cnt_reg == '0) begin
            cmd_reg   <= wr_reg ? sdra_pkg::CMD_WRITE : sdra_pkg::CMD_READ;
            addr_reg  <= sdra_pkg::ADDR_W'(col_reg);
            addr_reg[sdra_pkg::AP_BIT] <= 1'b1;
            dq_reg    <= wdata_reg;
            dq_oe_reg <= wr_reg;
            state_reg <= S_CMD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_CMD: begin
          cnt_reg   <= wr_reg ? CNT_W'(1) : CNT_W'(sdra_pkg::BURST_LEN +
                       (i_lat3 ? sdra_pkg::LAT_LONG : sdra_pkg::LAT_SHORT));
          state_reg <= S_DRAIN;
        end
        S_DRAIN: begin
          // Whole burst and auto precharge done first, so reads are never chained or cut
          if (cnt_reg == '0) begin
            cnt_reg   <= CNT_W'(sdra_pkg::RP_CYC);
            state_reg <= S_RP;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_RP: begin
          if (cnt_reg == '0) begin
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          ready_reg <= 1'b0;
        end
      endcase
    end
  end

  // Spacing between successive row opens
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      gap_reg <= '0;
    end else if (take) begin
      gap_reg <= CNT_W'(ACT_GAP);
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - 1'b1;
    end
  end

  assign bus.cmd     = cmd_reg;
  assign bus.bank    = bank_reg;
  assign bus.addr    = addr_reg;
  // Reads never overlap a write here, so mask stays low
  assign bus.dqm     = 1'b0;
  assign bus.c_dq    = dq_reg;
  assign bus.c_dq_oe = dq_oe_reg;
  assign o_req_ready = ready_reg;

  sdra_fifo #(
    .WIDTH (sdra_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_in_valid  (bus.d_dq_oe),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (bus.dq),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data),
    .o_count     (fifo_count)
  );
endmodule

// ==== design/sdra_dev.sv ====
// Purpose: SDRAM device end: row open state, read bursts, masking, precharge
// Assumes: Controller keeps spacing limits; commands come on the same clock
// Notes:   Storage is a small window indexed by bank and low column bits
// Function
// - Controller opens row before read or write
// - Access waits act_to_rw_delay after row open
// - Same-bank reopen needs precharge and act_to_act_same_bank
// - Other-bank opens spaced act_to_act_other_bank
// - Read carries column, bank, auto-precharge choice
// - First data read_latency cycles after command
// - Data lines released after burst ends
// - Full-page burst wraps to start column
// - New read continues data without gap
// - Chained read issued read_latency minus one early
// - Read accepted every cycle, any bank
// - Write follows read, idle cycle if needed
// - Mask high two clocks before write
// - Truncating write forces lines to high impedance
// - Mask low at write command
// - Precharge truncates read read_latency minus one early
// - No bank command until precharge_time elapses
// - Auto precharge equals earliest explicit precharge
// - Burst terminate issued read_latency minus one early
// - Address bit selects auto precharge per command
// - No auto precharge in full-page mode
// - Burst terminate leaves row open
`timescale 1ns/1ps
module sdra_dev #(
  parameter int MEM_COL_W = 4
) (
  input  wire logic                           i_mclk,      // System clock
  input  wire logic                           i_reset,     // Async reset, high
  sdra_if.device                              bus,         // Memory bus
  input  wire logic                           i_lat3,      // Read latency 3, else 2
  input  wire logic                           i_full_page, // Full-page read bursts
  output logic [sdra_pkg::NUM_BANKS-1:0]      o_bank_open  // Row open per bank
);
  localparam int NB        = sdra_pkg::NUM_BANKS;
  localparam int MEM_DEPTH = NB << MEM_COL_W;
  localparam int IDX_W     = sdra_pkg::BANK_W + MEM_COL_W;
  localparam int LEFT_W    = $clog2(sdra_pkg::BURST_LEN + 1);
  localparam int COL_W     = sdra_pkg::COL_W;

  generate
    if (MEM_COL_W < 1 || MEM_COL_W > COL_W) begin : g_bad
      $error("sdra_dev: MEM_COL_W out of range");
    end
  endgenerate

  function automatic logic [IDX_W-1:0] mem_idx(input logic [sdra_pkg::BANK_W-1:0] b,
                                               input logic [COL_W-1:0] c);
    return {b, c[MEM_COL_W-1:0]};
  endfunction

  // Wrap at page end back to the burst's start column
  function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] cur,
                                                input logic [COL_W-1:0] start);
    return (&cur) ? start : cur + 1'b1;
  endfunction

  logic [sdra_pkg::DATA_W-1:0]  mem_reg [MEM_DEPTH];
  logic [NB-1:0]                bank_open_reg;
  logic                         rd_act_reg;
  logic [sdra_pkg::BANK_W-1:0]  rd_bank_reg;
  logic [COL_W-1:0]             rd_col_reg;
  logic [COL_W-1:0]             rd_start_reg;
  logic [LEFT_W-1:0]            rd_left_reg;
  logic                         rd_ap_reg;
  logic                         rd_full_reg;
  logic                         ap_pend_reg;
  logic [sdra_pkg::BANK_W-1:0]  ap_bank_reg;
  logic [1:0]                   pipe_vld_reg;
  logic [sdra_pkg::DATA_W-1:0]  pipe_dat_reg [2];
  logic                         dqm_d1_reg;
  logic [sdra_pkg::DATA_W-1:0]  dq_reg;
  logic                         dq_oe_reg;

  logic                         cmd_read;
  logic                         cmd_write;
  logic                         cmd_pre;
  logic                         stop;
  logic                         gen_vld;
  logic [sdra_pkg::BANK_W-1:0]  gen_bank;
  logic [COL_W-1:0]             gen_col;
  logic                         gen_last;
  logic                         gen_ap;
  logic                         rd_busy;
  logic                         write_ok;
  logic                         sel_vld;
  logic [sdra_pkg::DATA_W-1:0]  sel_dat;
  logic [COL_W-1:0]             cmd_col;
  logic                         cmd_ap;

  assign cmd_col   = bus.addr[COL_W-1:0];
  assign cmd_ap    = bus.addr[sdra_pkg::AP_BIT];
  assign cmd_read  = (bus.cmd == sdra_pkg::CMD_READ) && bank_open_reg[bus.bank];
  assign cmd_write = (bus.cmd == sdra_pkg::CMD_WRITE);
  assign cmd_pre   = (bus.cmd == sdra_pkg::CMD_PRE);
  // Write, terminate or precharge of the reading bank stop generation
  assign stop = cmd_write || (bus.cmd == sdra_pkg::CMD_BST) ||
                (cmd_pre && (cmd_ap || bus.bank == rd_bank_reg));

  always_comb begin
    gen_vld  = 1'b0;
    gen_bank = rd_bank_reg;
    gen_col  = rd_col_reg;
    gen_last = !rd_full_reg && (rd_left_reg == LEFT_W'(1));
    gen_ap   = rd_ap_reg;
    if (cmd_read) begin
      gen_vld  = 1'b1;
      gen_bank = bus.bank;
      gen_col  = cmd_col;
      gen_last = !i_full_page && (sdra_pkg::BURST_LEN == 1);
      gen_ap   = cmd_ap && !i_full_page;
    end else if (rd_act_reg && !stop) begin
      gen_vld = 1'b1;
    end
  end

  // Burst engine: one element per cycle from the command edge on
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rd_act_reg   <= 1'b0;
      rd_bank_reg  <= '0;
      rd_col_reg   <= '0;
      rd_start_reg <= '0;
      rd_left_reg  <= '0;
      rd_ap_reg    <= 1'b0;
      rd_full_reg  <= 1'b0;
    end else if (cmd_read) begin
      rd_act_reg   <= !gen_last;
      rd_bank_reg  <= bus.bank;
      rd_col_reg   <= next_col(cmd_col, cmd_col);
      rd_start_reg <= cmd_col;
      rd_left_reg  <= LEFT_W'(sdra_pkg::BURST_LEN - 1);
      rd_ap_reg    <= gen_ap;
      rd_full_reg  <= i_full_page;
    end else if (stop) begin
      rd_act_reg <= 1'b0;
    end else if (rd_act_reg) begin
      rd_col_reg  <= next_col(rd_col_reg, rd_start_reg);
      rd_left_reg <= rd_left_reg - 1'b1;
      if (gen_last) begin
        rd_act_reg <= 1'b0;
      end
    end
  end

  // Auto precharge lands on the edge an explicit one earliest could
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ap_pend_reg <= 1'b0;
      ap_bank_reg <= '0;
    end else begin
      ap_pend_reg <= (gen_vld && gen_last && gen_ap) || (cmd_write && cmd_ap);
      ap_bank_reg <= cmd_write ? bus.bank : gen_bank;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      bank_open_reg <= '0;
    end else begin
      if (ap_pend_reg) begin
        bank_open_reg[ap_bank_reg] <= 1'b0;
      end
      if (bus.cmd == sdra_pkg::CMD_ACT) begin
        bank_open_reg[bus.bank] <= 1'b1;
      end else if (cmd_pre && cmd_ap) begin
        bank_open_reg <= '0;
      end else if (cmd_pre) begin
        bank_open_reg[bus.bank] <= 1'b0;
      end
      // Burst terminate leaves bank state untouched
    end
  end

  // Mask sampled one edge back gates the output two edges after capture
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      dqm_d1_reg <= 1'b1;
    end else begin
      dqm_d1_reg <= bus.dqm;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      pipe_vld_reg <= '0;
    end else if (cmd_write) begin
      pipe_vld_reg <= '0;
    end else begin
      pipe_vld_reg <= {pipe_vld_reg[0], gen_vld};
    end
  end

  always_ff @(posedge i_mclk) begin
    pipe_dat_reg[0] <= mem_reg[mem_idx(gen_bank, gen_col)];
    pipe_dat_reg[1] <= pipe_dat_reg[0];
  end

  assign sel_vld = i_lat3 ? pipe_vld_reg[1] : pipe_vld_reg[0];
  assign sel_dat = i_lat3 ? pipe_dat_reg[1] : pipe_dat_reg[0];

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      dq_reg    <= '0;
      dq_oe_reg <= 1'b0;
    end else begin
      dq_reg    <= sel_dat;
      // Empty pipe releases the lines
      dq_oe_reg <= sel_vld && !dqm_d1_reg && !cmd_write;
    end
  end

  // A write cutting into live output is dropped unless mask was high
  assign rd_busy  = rd_act_reg || (|pipe_vld_reg) || dq_oe_reg;
  assign write_ok = cmd_write && bank_open_reg[bus.bank] && !bus.dqm &&
                    (dqm_d1_reg || !rd_busy);

  always_ff @(posedge i_mclk) begin
    if (write_ok) begin
      mem_reg[mem_idx(bus.bank, cmd_col)] <= bus.dq;
    end
  end

  assign bus.d_dq    = dq_reg;
  assign bus.d_dq_oe = dq_oe_reg;
  assign o_bank_open = bank_open_reg;
endmodule

// ==== design/sdra_fifo.sv ====
// Purpose: Read-data FIFO on the controller side
// Assumes: Single clock; push and pop may coincide
// Notes:   Flip-flop storage; count exported for burst-sized room checks
`timescale 1ns/1ps
module sdra_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic                       i_mclk,     // System clock
  input  wire logic                       i_reset,    // Async reset, high
  input  wire logic                       i_in_valid, // Push request
  output logic                            o_in_ready, // Not full
  input  wire logic [WIDTH-1:0]           i_in_data,  // Push data
  output logic                            o_out_valid, // Not empty
  input  wire logic                       i_out_ready, // Pop request
  output logic [WIDTH-1:0]                o_out_data, // Head word
  output logic [$clog2(DEPTH+1)-1:0]      o_count     // Words held
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("sdra_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W:0]   wptr_reg;
  logic [PTR_W:0]   rptr_reg;
  logic             push;
  logic             pop;

  assign o_count     = CNT_W'(wptr_reg - rptr_reg);
  assign o_in_ready  = (o_count != CNT_W'(DEPTH));
  assign o_out_valid = (wptr_reg != rptr_reg);
  assign o_out_data  = mem_reg[rptr_reg[PTR_W-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wptr_reg[PTR_W-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule

// ==== design/sdra_if.sv ====
// Purpose: Command, address, mask and data lines between controller and SDRAM
// Assumes: Both ends clocked by the same i_mclk
// Notes:   Data lines resolved here from the two output enables
`timescale 1ns/1ps
interface sdra_if;
  sdra_pkg::sdra_cmd_e                cmd;
  logic [sdra_pkg::BANK_W-1:0]        bank;
  logic [sdra_pkg::ADDR_W-1:0]        addr;
  logic                               dqm;
  logic [sdra_pkg::DATA_W-1:0]        c_dq;
  logic                               c_dq_oe;
  logic [sdra_pkg::DATA_W-1:0]        d_dq;
  logic                               d_dq_oe;
  logic [sdra_pkg::DATA_W-1:0]        dq;

  // Undriven bus reads as zero
  assign dq = d_dq_oe ? d_dq : (c_dq_oe ? c_dq : '0);

  modport device (input cmd, bank, addr, dqm, dq, output d_dq, d_dq_oe);
  modport ctrl   (output cmd, bank, addr, dqm, c_dq, c_dq_oe, input dq, d_dq_oe);
endinterface

// ==== design/sdra_pkg.sv ====
// Purpose: Shared constants and command codes for the SDRAM read-path pair
// Assumes: Both ends run on one 250 MHz clock
// Notes:   Timing figures in ns are plain defaults; cycle counts derive from them
package sdra_pkg;
  localparam int NUM_BANKS     = 4;
  localparam int BANK_W        = 2;
  localparam int ROW_W         = 13;
  localparam int COL_W         = 10;
  localparam int ADDR_W        = 13;
  localparam int DATA_W        = 16;
  localparam int AP_BIT        = 10;   // auto_precharge_select_bit
  localparam int BURST_LEN     = 4;
  localparam int LAT_SHORT     = 2;
  localparam int LAT_LONG      = 3;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_NS     = 1000;

  localparam int ACT_TO_RW_DELAY_NS       = 20;
  localparam int ACT_TO_ACT_SAME_BANK_NS  = 66;
  localparam int ACT_TO_ACT_OTHER_BANK_NS = 15;
  localparam int PRECHARGE_TIME_NS        = 20;

  // Least times round up, never below one cycle
  function automatic int cyc_min(input int t_ns);
    int c;
    c = (t_ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RCD_CYC = cyc_min(ACT_TO_RW_DELAY_NS);
  localparam int RC_CYC  = cyc_min(ACT_TO_ACT_SAME_BANK_NS);
  localparam int RRD_CYC = cyc_min(ACT_TO_ACT_OTHER_BANK_NS);
  localparam int RP_CYC  = cyc_min(PRECHARGE_TIME_NS);

  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_ACT   = 3'h1,
    CMD_READ  = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_PRE   = 3'h4,
    CMD_BST   = 3'h5
  } sdra_cmd_e;
endpackage

// ==== sim/sdra_monitor.sv ====
// Purpose: Protocol checker on the memory bus between controller and device
// Assumes: Controller runs serial closed-page accesses with fixed bursts
// Notes:   Spacing counters saturate so reset looks like a long idle time
`timescale 1ns/1ps
module sdra_monitor (
  input  wire logic                          i_mclk,      // System clock
  input  wire logic                          i_reset,     // Async reset, high
  input  sdra_pkg::sdra_cmd_e                cmd,         // Bus command
  input  wire logic [sdra_pkg::BANK_W-1:0]   bank,        // Bank select
  input  wire logic [sdra_pkg::ADDR_W-1:0]   addr,        // Address
  input  wire logic                          dqm,         // Data mask
  input  wire logic                          c_dq_oe,     // Controller drives data
  input  wire logic                          d_dq_oe,     // Device drives data
  input  wire logic                          i_lat3,      // Read latency 3
  input  wire logic                          i_full_page, // Full-page bursts
  input  wire logic [sdra_pkg::NUM_BANKS-1:0] o_bank_open // Row open per bank
);
  logic [5:0] act_gap_reg;
  logic [5:0] pre_gap_reg;
  logic [3:0] open_q_reg;
  wire logic  rd_ok = (cmd == sdra_pkg::CMD_READ) && o_bank_open[bank];
  wire logic  closed = |(open_q_reg & ~o_bank_open);

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) act_gap_reg <= 6'h3F;
    else if (cmd == sdra_pkg::CMD_ACT) act_gap_reg <= 6'h01;
    else if (act_gap_reg != 6'h3F) act_gap_reg <= act_gap_reg + 6'h01;
  end

  // Precharge seen one edge late, through the open flags
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) pre_gap_reg <= 6'h3F;
    else if (closed) pre_gap_reg <= 6'h01;
    else if (pre_gap_reg != 6'h3F) pre_gap_reg <= pre_gap_reg + 6'h01;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) open_q_reg <= 4'h0;
    else open_q_reg <= o_bank_open;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  AST_RD_OPEN: assert property (cmd == sdra_pkg::CMD_READ |-> o_bank_open[bank])
    else $error("read to a closed bank");
  AST_RCD: assert property (cmd == sdra_pkg::CMD_ACT |=> (cmd == sdra_pkg::CMD_NOP)[*4]
    ##1 (cmd == sdra_pkg::CMD_READ || cmd == sdra_pkg::CMD_WRITE)) else $error("open to access");
  AST_ACT_GAP: assert property (cmd == sdra_pkg::CMD_ACT |->
    act_gap_reg >= sdra_pkg::RC_CYC) else $error("row opens too close");
  AST_PRE_GAP: assert property (cmd == sdra_pkg::CMD_ACT |->
    pre_gap_reg >= sdra_pkg::RP_CYC - 1) else $error("open before precharge time");
  AST_LAT2: assert property (rd_ok && !i_lat3 |=> !d_dq_oe ##1 d_dq_oe)
    else $error("latency two data late or early");
  AST_LAT3: assert property (rd_ok && i_lat3 |=> !d_dq_oe[*2] ##1 d_dq_oe)
    else $error("latency three data late or early");
  AST_BURST: assert property ($rose(d_dq_oe) && !i_full_page |-> d_dq_oe[*4] ##1 !d_dq_oe)
    else $error("burst length or release wrong");
  AST_AUTO_PRE: assert property (rd_ok && addr[sdra_pkg::AP_BIT] &&
    !i_full_page |-> ##4 o_bank_open[$past(bank, 4)] ##1 !o_bank_open[$past(bank, 5)])
    else $error("auto close");
  AST_WR_MASK: assert property (cmd == sdra_pkg::CMD_WRITE |->
    !dqm && c_dq_oe && !d_dq_oe) else $error("write with mask or contention");
  AST_WR_HIZ: assert property (cmd == sdra_pkg::CMD_WRITE |=> !d_dq_oe)
    else $error("device drives after write");

  COV_READ: cover property (rd_ok ##1 !d_dq_oe);
  COV_WRITE: cover property (cmd == sdra_pkg::CMD_WRITE);
  COV_CLOSE: cover property (closed);
endmodule

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the controller and device pair
// Assumes: Fixed bursts of four with auto precharge from the controller
// Notes:   Model keyed like the device window, so the row is not checked
`timescale 1ns/1ps
module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_reset = 1'b1;
  logic        lat3 = 1'b0;
  logic        rq_valid = 1'b0;
  logic        rq_write = 1'b0;
  logic        rd_ready = 1'b0;
  logic [1:0]  rq_bank = 2'h0;
  logic [12:0] rq_row = 13'h0000;
  logic [9:0]  rq_col = 10'h000;
  logic [15:0] rq_wdata = 16'h0000;
  logic [15:0] mem [64];
  logic [3:0]  bank_open;
  logic        rq_ready;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic [1:0]  tb_bank;
  logic [9:0]  tb_col;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          hits;
  sdra_if bus ();

  always #2 i_mclk = ~i_mclk;

  sdra_dev i_sdra_dev (.i_mclk(i_mclk), .i_reset(i_reset), .bus(bus), .i_lat3(lat3),
    .i_full_page(1'b0), .o_bank_open(bank_open));
  sdra_ctrl i_sdra_ctrl (.i_mclk(i_mclk), .i_reset(i_reset), .bus(bus), .i_lat3(lat3),
    .i_req_valid(rq_valid), .o_req_ready(rq_ready), .i_req_write(rq_write),
    .i_req_bank(rq_bank), .i_req_row(rq_row), .i_req_col(rq_col), .i_req_wdata(rq_wdata),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_data(rd_data));
  sdra_monitor i_sdra_monitor (.i_mclk(i_mclk), .i_reset(i_reset), .cmd(bus.cmd),
    .bank(bus.bank), .addr(bus.addr), .dqm(bus.dqm), .c_dq_oe(bus.c_dq_oe),
    .d_dq_oe(bus.d_dq_oe), .i_lat3(lat3), .i_full_page(1'b0), .o_bank_open(bank_open));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_word(input logic [1:0] b, input logic [9:0] c);
    return mem[{b, c[3:0]}];
  endfunction

  // Held from a falling edge until the rising edge that sees ready high
  task automatic request(input logic w, input logic [1:0] b, input logic [9:0] c);
    @(negedge i_mclk);
    rq_valid = 1'b1;
    rq_write = w;
    rq_bank = b;
    rq_row = 13'($urandom);
    rq_col = c;
    rq_wdata = 16'($urandom);
    if (w) mem[{b, c[3:0]}] = rq_wdata;
    while (rq_ready !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    rq_valid = 1'b0;
  endtask

  // Random stall models a slow consumer; at least one edge so ready drops between pops
  task automatic pop(input logic [15:0] exp);
    repeat (1 + $urandom % 3) @(negedge i_mclk);
    while (rd_valid !== 1'b1) @(negedge i_mclk);
    check("read word", rd_data, exp);
    rd_ready = 1'b1;
    @(negedge i_mclk);
    rd_ready = 1'b0;
  endtask

  task automatic round(input logic [1:0] b, input logic [9:0] c);
    for (int i = 0; i < 4; i++) request(1'b1, b, c + 10'(i));
    request(1'b0, b, c);
    for (int i = 0; i < 4; i++) pop(exp_word(b, c + 10'(i)));
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(83));
    for (int p = 0; p < 2; p++) begin
      i_reset = 1'b1;
      lat3 = p[0];
      repeat (10) @(negedge i_mclk);
      i_reset = 1'b0;
      for (int r = 0; r < 6; r++) begin
        tb_bank = 2'($urandom);
        tb_col = (r == 0) ? 10'h000 : (r == 1) ? 10'h3FC : 10'($urandom % 1020);
        round(tb_bank, tb_col);
      end
    end
    // Consumer stalled: eight bursts fill all 32 words, then ready must stay low
    for (int i = 0; i < 8; i++) request(1'b0, tb_bank, tb_col);
    hits = 0;
    repeat (60) begin
      @(negedge i_mclk);
      if (rq_ready !== 1'b0) hits++;
    end
    check("ready while full", 16'(hits), 16'h0000);
    for (int i = 0; i < 32; i++) pop(exp_word(tb_bank, tb_col + 10'(i % 4)));
    repeat (3) @(negedge i_mclk);
    check("empty after drain", {15'h0000, rd_valid}, 16'h0000);
    give_verdict();
  end
endmodule
